//--- hw/psr_regs.vh
`ifndef PSR_REGS_VH
`define PSR_REGS_VH
// Functional notes
// - idle inputs for idle period enter standby
// - any input transition wakes from standby
// - pulses over 5ns detected, under 1ns ignored; the code only sees levels present at a 10ns clock edge
// - power-down pin high holds standby, low resumes
// - power-down pin never feeds the logic array
// - power-up reset clears all registers within 10us
// - registered outputs show polarity of cleared register
// - synchronous preload forces any register state
// - 64-bit reprogrammable user signature store
// - signature readable regardless of security cell
// - programmed security cell blocks configuration readback
// - security cell cleared only by full reprogramming; rst_b also clears it in the code
// - programming cycle erases automatically first
// - accept 5892-fuse map or 5828-fuse map

// ****************************************************************
// widths and counts
// ****************************************************************
`define PSR_NIN        12
`define PSR_NREG       10
`define PSR_SIG_W      64
`define PSR_CFG_W      16
`define PSR_CFG_DEPTH  368
`define PSR_CFG_AW     9
`define PSR_FUSE_FULL  13'h1704
`define PSR_FUSE_STD   13'h16C4
`define PSR_FUSE_W     13
`define PSR_FUSE_STEP  13'h0010

// ****************************************************************
// timing at 100 MHz, 10 ns period
// ****************************************************************
`define PSR_CLK_NS     10
`define PSR_IDLE_NS    100
`define PSR_IDLE_CYC   ((`PSR_IDLE_NS + `PSR_CLK_NS - 1) / `PSR_CLK_NS)
`define PSR_PULSE_NS   5
`define PSR_PULSE_CYC  ((`PSR_PULSE_NS + `PSR_CLK_NS - 1) / `PSR_CLK_NS)
`define PSR_POR_US     10
`define PSR_POR_CYC    ((`PSR_POR_US * 1000) / `PSR_CLK_NS)
`define PSR_CNT_W      16

// ****************************************************************
// programming states
// ****************************************************************
`define PSR_ST_IDLE    2'h0
`define PSR_ST_ERASE   2'h1
`define PSR_ST_LOAD    2'h2
`define PSR_ST_READ    2'h3
`endif

//--- hw/psr_cfg_mem.v
`include "psr_regs.vh"

module psr_cfg_mem (
  input  wire                     sys_clk,
  input  wire                     wr_en,
  input  wire [`PSR_CFG_AW-1:0]   wr_addr,
  input  wire [`PSR_CFG_W-1:0]    wr_data,
  input  wire [`PSR_CFG_AW-1:0]   rd_addr,
  output reg  [`PSR_CFG_W-1:0]    rd_data
);
  reg [`PSR_CFG_W-1:0] mem [0:`PSR_CFG_DEPTH-1];

  always @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // psr_cfg_mem

//--- hw/psr_top.v
`include "psr_regs.vh"

module psr_top (
  input  wire                    sys_clk,
  input  wire                    rst_b,
  input  wire                    variant_pin_mode,
  input  wire                    power_down_pin,
  input  wire [`PSR_NIN-1:0]     pin_in,
  input  wire [`PSR_NREG-1:0]    next_state,
  input  wire [`PSR_NREG-1:0]    out_polarity,
  input  wire [`PSR_NREG-1:0]    out_enable,
  input  wire                    preload_en,
  input  wire [`PSR_NREG-1:0]    preload_data,
  input  wire                    prog_start,
  input  wire                    prog_full_map,
  input  wire                    prog_wr,
  input  wire [`PSR_CFG_W-1:0]   prog_data,
  input  wire                    prog_secure,
  input  wire                    cfg_rd_req,
  input  wire [`PSR_CFG_AW-1:0]  cfg_rd_addr,
  output reg  [`PSR_NREG-1:0]    reg_out,
  output reg  [`PSR_NREG-1:0]    reg_out_oe,
  output reg  [`PSR_NIN-1:0]     array_in,
  output reg                     standby,
  output reg                     por_done,
  output reg  [`PSR_SIG_W-1:0]   user_signature,
  output reg                     secure_cell,
  output reg                     prog_busy,
  output reg                     cfg_rd_valid,
  output reg                     cfg_rd_denied,
  output reg  [`PSR_CFG_W-1:0]   cfg_rd_data
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  reg [`PSR_NIN-1:0]  in_s1_reg;
  reg [`PSR_NIN-1:0]  in_s2_reg;
  reg [`PSR_NIN-1:0]  in_s3_reg;
  reg                 pd_s1_reg;
  reg                 pd_s2_reg;

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_s1_reg <= {`PSR_NIN{1'b0}};
      in_s2_reg <= {`PSR_NIN{1'b0}};
      in_s3_reg <= {`PSR_NIN{1'b0}};
      pd_s1_reg <= 1'b0;
      pd_s2_reg <= 1'b0;
    end
    else
    begin
      in_s1_reg <= pin_in;
      in_s2_reg <= in_s1_reg;
      in_s3_reg <= in_s2_reg;
      pd_s1_reg <= power_down_pin;
      pd_s2_reg <= pd_s1_reg;
    end
  end

  // ****************************************************************
  // power-up reset counter
  // ****************************************************************
  reg [`PSR_CNT_W-1:0] por_cnt_reg;

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      por_cnt_reg <= {`PSR_CNT_W{1'b0}};
      por_done    <= 1'b0;
    end
    else if (!por_done)
    begin
      // registers already cleared by reset; done after PSR_POR_CYC cycles, the full 10us limit
      if (por_cnt_reg == `PSR_POR_CYC - 1)
        por_done <= 1'b1;
      por_cnt_reg <= por_cnt_reg + 1'b1;
    end
  end

  // ****************************************************************
  // transition detection and standby
  // ****************************************************************
  // a change counts once a clock edge samples it, however short: a glitch
  // that spans an edge reaches the second stage, one between edges never does
  wire [`PSR_NIN-1:0] chg = in_s2_reg ^ in_s3_reg;
  // all PSR_NIN pin_in bits are watched, but they drive standby only when variant_pin_mode is low; the separate power-down pin is not among them
  wire                any_chg = |chg;
  reg  [`PSR_CNT_W-1:0] idle_cnt_reg;
  wire                idle_stdby;

  assign idle_stdby = (idle_cnt_reg >= `PSR_IDLE_CYC);

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idle_cnt_reg <= {`PSR_CNT_W{1'b0}};
      standby      <= 1'b0;
    end
    else
    begin
      if (any_chg)
        idle_cnt_reg <= {`PSR_CNT_W{1'b0}};
      else if (!idle_stdby)
        idle_cnt_reg <= idle_cnt_reg + 1'b1;
      if (variant_pin_mode)
        standby <= pd_s2_reg;
      else
        standby <= idle_stdby && !any_chg;
    end
  end

  // ****************************************************************
  // output registers with preload
  // ****************************************************************
  reg [`PSR_NREG-1:0] state_reg;
  reg [`PSR_NREG-1:0] state_next;

  always @*
  begin
    state_next = state_reg;
    if (preload_en)
      state_next = preload_data;
    else if (!standby && por_done)
      state_next = next_state;
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg  <= {`PSR_NREG{1'b0}};
      reg_out    <= {`PSR_NREG{1'b0}};
      reg_out_oe <= {`PSR_NREG{1'b0}};
      array_in   <= {`PSR_NIN{1'b0}};
    end
    else
    begin
      state_reg  <= state_next;
      reg_out    <= state_next ^ out_polarity;
      reg_out_oe <= out_enable;
      array_in   <= in_s2_reg;
      if (variant_pin_mode)
        array_in[0] <= 1'b0;
    end
  end

  // ****************************************************************
  // programming, security and readback
  // ****************************************************************
  reg  [1:0]              pst_reg;
  reg  [`PSR_CFG_AW-1:0]  addr_reg;
  reg  [`PSR_FUSE_W-1:0]  fuse_cnt_reg;
  reg  [`PSR_FUSE_W-1:0]  fuse_lim_reg;
  reg                     rd_pend_reg;
  wire                    mem_we;
  wire [`PSR_CFG_W-1:0]   mem_wd;
  wire [`PSR_CFG_AW-1:0]  mem_ra;
  wire [`PSR_CFG_W-1:0]   mem_rd;
  wire                    sig_word;

  assign sig_word = (fuse_cnt_reg >= `PSR_FUSE_STD);
  assign mem_we   = (pst_reg == `PSR_ST_ERASE) || (pst_reg == `PSR_ST_LOAD && prog_wr);
  assign mem_wd   = (pst_reg == `PSR_ST_ERASE) ? {`PSR_CFG_W{1'b0}} : prog_data;
  assign mem_ra   = cfg_rd_addr;

  psr_cfg_mem u_mem (
    .sys_clk (sys_clk),
    .wr_en   (mem_we),
    .wr_addr (addr_reg),
    .wr_data (mem_wd),
    .rd_addr (mem_ra),
    .rd_data (mem_rd)
  );

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pst_reg        <= `PSR_ST_IDLE;
      addr_reg       <= {`PSR_CFG_AW{1'b0}};
      fuse_cnt_reg   <= {`PSR_FUSE_W{1'b0}};
      fuse_lim_reg   <= `PSR_FUSE_FULL;
      user_signature <= {`PSR_SIG_W{1'b0}};
      secure_cell    <= 1'b0;
      prog_busy      <= 1'b0;
      rd_pend_reg    <= 1'b0;
      cfg_rd_valid   <= 1'b0;
      cfg_rd_denied  <= 1'b0;
      cfg_rd_data    <= {`PSR_CFG_W{1'b0}};
    end
    else
    begin
      cfg_rd_valid  <= 1'b0;
      cfg_rd_denied <= 1'b0;
      rd_pend_reg   <= 1'b0;
      case (pst_reg)
        `PSR_ST_IDLE:
        begin
          if (prog_start)
          begin
            pst_reg     <= `PSR_ST_ERASE;
            addr_reg    <= {`PSR_CFG_AW{1'b0}};
            prog_busy   <= 1'b1;
            secure_cell <= 1'b0;
            fuse_lim_reg <= prog_full_map ? `PSR_FUSE_FULL : `PSR_FUSE_STD;
          end
          else if (cfg_rd_req)
          begin
            if (secure_cell)
              cfg_rd_denied <= 1'b1;
            else
              rd_pend_reg <= 1'b1;
          end
        end
        `PSR_ST_ERASE:
        begin
          if (addr_reg == `PSR_CFG_DEPTH - 1)
          begin
            pst_reg        <= `PSR_ST_LOAD;
            addr_reg       <= {`PSR_CFG_AW{1'b0}};
            fuse_cnt_reg   <= {`PSR_FUSE_W{1'b0}};
            user_signature <= {`PSR_SIG_W{1'b0}};
          end
          else
            addr_reg <= addr_reg + 1'b1;
        end
        `PSR_ST_LOAD:
        begin
          if (prog_wr)
          begin
            if (sig_word)
              user_signature <= {user_signature[`PSR_SIG_W-`PSR_CFG_W-1:0], prog_data};
            addr_reg     <= addr_reg + 1'b1;
            fuse_cnt_reg <= fuse_cnt_reg + `PSR_FUSE_STEP;
            if (fuse_cnt_reg + `PSR_FUSE_STEP >= fuse_lim_reg)
            begin
              pst_reg     <= `PSR_ST_IDLE;
              prog_busy   <= 1'b0;
              secure_cell <= prog_secure;
            end
          end
        end
        default:
          pst_reg <= `PSR_ST_IDLE;
      endcase
      if (rd_pend_reg)
      begin
        cfg_rd_valid <= 1'b1;
        cfg_rd_data  <= mem_rd;
      end
    end
  end
  // user_signature port is a plain register output, never gated by security
endmodule // psr_top

//--- test/psr_assertions.sv
`include "psr_regs.vh"

module psr_chk (
  input wire logic                 sys_clk,
  input wire logic                 rst_b,
  input wire logic                 variant_pin_mode,
  input wire logic                 power_down_pin,
  input wire logic [`PSR_NIN-1:0]  pin_in,
  input wire logic [`PSR_NREG-1:0] out_polarity,
  input wire logic                 preload_en,
  input wire logic [`PSR_NREG-1:0] preload_data,
  input wire logic [`PSR_NREG-1:0] reg_out,
  input wire logic [`PSR_NIN-1:0]  array_in,
  input wire logic                 standby,
  input wire logic                 por_done,
  input wire logic                 secure_cell,
  input wire logic                 prog_busy,
  input wire logic                 cfg_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ****
  // power-up counter
  // ****
  logic [15:0] por_cnt_reg;
  always @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      por_cnt_reg <= 16'h0000;
    else if (!por_done)
      por_cnt_reg <= por_cnt_reg + 16'h0001;
  a_por_bound: assert property (!por_done |-> por_cnt_reg < `PSR_POR_CYC)
    else $error("power-up reset overran");
  a_preload_state: assert property (preload_en ##1 $stable(out_polarity)
    |-> reg_out == ($past(preload_data) ^ out_polarity)) else $error("preload not taken");
  a_pin_sleep: assert property (variant_pin_mode && $rose(power_down_pin) |-> ##3 standby)
    else $error("power-down pin did not sleep");
  a_pin_wake: assert property (variant_pin_mode && $fell(power_down_pin) |-> ##3 !standby)
    else $error("power-down pin did not wake");
  a_pin_reserved: assert property (variant_pin_mode |-> array_in[0] == 1'b0)
    else $error("power-down input reached array");
  a_idle_early: assert property ($rose(standby) && !variant_pin_mode |-> $past(pin_in, 10) == pin_in)
    else $error("standby entered while pins moved");
  a_wake_fast: assert property (!variant_pin_mode && standby && pin_in != $past(pin_in)
    |-> ##[1:5] !standby) else $error("transition did not wake");
  a_read_locked: assert property (cfg_rd_valid |-> !secure_cell)
    else $error("readback while secured");
  a_erase_unlock: assert property ($rose(prog_busy) |-> ##[0:2] !secure_cell)
    else $error("security not cleared by erase");
endmodule // psr_chk

bind psr_top psr_chk u_psr_chk (.sys_clk, .rst_b, .variant_pin_mode, .power_down_pin, .pin_in,
  .out_polarity, .preload_en, .preload_data, .reg_out, .array_in, .standby, .por_done,
  .secure_cell, .prog_busy, .cfg_rd_valid);

//--- test/psr_sys_model.sv
`include "psr_regs.vh"

module psr_sys_model (
  input  wire logic                 sys_clk,
  input  wire logic                 por_done,
  input  wire logic                 tog,
  input  wire logic                 pd,
  output logic      [`PSR_NIN-1:0]  pin_in = '0,
  output logic                      power_down_pin = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins stay still until power-up settles; each level lasts whole cycles, far over 5ns
  always @(posedge sys_clk)
  begin
    if (tog && por_done)
      pin_in <= ~pin_in;
    power_down_pin <= pd && por_done;
  end
endmodule // psr_sys_model

//--- test/testbench.sv
`include "psr_regs.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [`PSR_NREG-1:0] POL = 10'h155;
  logic sys_clk = 1'b0, rst_b = 1'b0, variant_pin_mode = 1'b0, tog = 1'b0, pd = 1'b0;
  logic preload_en = 1'b0, prog_start = 1'b0, prog_full_map = 1'b0, prog_wr = 1'b0;
  logic prog_secure = 1'b0, cfg_rd_req = 1'b0, power_down_pin, standby, por_done;
  logic secure_cell, prog_busy, cfg_rd_valid, cfg_rd_denied, got_v, got_d;
  logic [`PSR_NIN-1:0]    pin_in, array_in;
  logic [`PSR_NREG-1:0]   next_state = 10'h000, preload_data = 10'h000, reg_out, reg_out_oe, out_en = 10'h3FF;
  logic [`PSR_CFG_W-1:0]  prog_data = 16'h0000, cfg_rd_data, got_data;
  logic [`PSR_CFG_AW-1:0] cfg_rd_addr = 9'h000;
  logic [`PSR_SIG_W-1:0]  user_signature;
  int bad_count = 0, compares = 0;

  always #5 sys_clk = ~sys_clk;

  psr_sys_model u_psr_sys_model (.sys_clk, .por_done, .tog, .pd, .pin_in, .power_down_pin);
  psr_top u_psr_top (.sys_clk, .rst_b, .variant_pin_mode, .power_down_pin, .pin_in, .next_state,
    .out_polarity(POL), .out_enable(out_en), .preload_en, .preload_data, .prog_start, .prog_full_map,
    .prog_wr, .prog_data, .prog_secure, .cfg_rd_req, .cfg_rd_addr, .reg_out, .reg_out_oe, .array_in,
    .standby, .por_done, .user_signature, .secure_cell, .prog_busy, .cfg_rd_valid, .cfg_rd_denied,
    .cfg_rd_data);

  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task wait_sb(input logic v);
    int n;
    n = 0;
    while (standby !== v && n < 40)
    begin
      tick(1);
      n++;
    end
    chk(standby, v);
  endtask

  task do_reset(input logic mode);
    int n;
    @(posedge sys_clk) rst_b <= 1'b0;
    variant_pin_mode <= mode;
    tick(3);
    @(posedge sys_clk) rst_b <= 1'b1;
    n = 0;
    while (por_done !== 1'b1 && n < 10100)
    begin
      tick(1);
      n++;
    end
    chk(n, `PSR_POR_CYC);
    chk(reg_out, POL);
    chk(reg_out_oe, out_en);
  endtask

  task prog(input logic full, input logic sec, input logic [15:0] base, input int nw);
    int i;
    @(posedge sys_clk) prog_start <= 1'b1;
    prog_full_map <= full;
    prog_secure <= sec;
    @(posedge sys_clk) prog_start <= 1'b0;
    tick(372);
    for (i = 0; i < nw; i++)
    begin
      @(posedge sys_clk) prog_wr <= 1'b1;
      prog_data <= base + i[15:0];
      @(posedge sys_clk) prog_wr <= 1'b0;
    end
    tick(4);
    chk(prog_busy, 1'h0);
  endtask

  task rd(input logic [8:0] a);
    int n;
    got_v = 1'b0;
    got_d = 1'b0;
    @(posedge sys_clk) cfg_rd_req <= 1'b1;
    cfg_rd_addr <= a;
    @(posedge sys_clk) cfg_rd_req <= 1'b0;
    for (n = 0; n < 4; n++)
    begin
      // look just after each edge: the answer pulses stand one cycle only
      #1;
      got_v |= (cfg_rd_valid === 1'b1);
      got_d |= (cfg_rd_denied === 1'b1);
      if (cfg_rd_valid === 1'b1)
        got_data = cfg_rd_data;
      @(posedge sys_clk);
    end
  endtask

  // ****
  // scenarios
  // ****
  initial
  begin
    do_reset(1'b0);
    @(posedge sys_clk) next_state <= 10'h0F0;
    tog <= 1'b1;
    @(posedge sys_clk) tog <= 1'b0;
    wait_sb(1'b0);
    tick(2);
    chk(reg_out, 10'h0F0 ^ POL);
    @(posedge sys_clk) preload_en <= 1'b1;
    preload_data <= 10'h3C3;
    @(posedge sys_clk) preload_en <= 1'b0;
    #1 chk(reg_out, 10'h3C3 ^ POL);
    wait_sb(1'b1);
    @(posedge sys_clk) next_state <= 10'h2AA;
    tick(5);
    chk(reg_out, 10'h0F0 ^ POL);
    @(posedge sys_clk) tog <= 1'b1;
    @(posedge sys_clk) tog <= 1'b0;
    wait_sb(1'b0);
    tick(2);
    chk(reg_out, 10'h2AA ^ POL);
    prog(1'b1, 1'b1, 16'h0000, 369);
    chk(secure_cell, 1'h1);
    chk(user_signature, 64'h016D016E016F0170);
    rd(9'h005);
    chk({got_v, got_d}, 2'h1);
    chk(user_signature, 64'h016D016E016F0170);
    prog(1'b0, 1'b0, 16'h1000, 365);
    chk(secure_cell, 1'h0);
    chk(user_signature, 64'h0);
    rd(9'h005);
    chk({got_v, got_d, got_data}, {2'h2, 16'h1005});
    rd(9'h16F);
    chk(got_data, 16'h0000);
    out_en <= 10'h2C7;
    do_reset(1'b1);
    tick(30);
    chk(standby, 1'h0);
    @(posedge sys_clk) pd <= 1'b1;
    tog <= 1'b1;
    @(posedge sys_clk) tog <= 1'b0;
    wait_sb(1'b1);
    chk(array_in, {pin_in[11:1], 1'b0});
    @(posedge sys_clk) pd <= 1'b0;
    wait_sb(1'b0);
    stop_test;
  end

  initial
  begin
    #400000;
    bad_count++;
    stop_test;
  end
endmodule // testbench
